// [hdl/tdmsp_pkg.sv]
package tdmsp_pkg;

    // ****************************************
    // Word and frame geometry
    // ****************************************
    localparam int unsigned WORD_BITS    = 16;
    localparam logic [3:0]  BIT_FIRST    = 4'h0;
    localparam logic [3:0]  BIT_LAST     = 4'hf;
    localparam logic [5:0]  SLOT_FIRST   = 6'h00;
    localparam logic [5:0]  SLOT_NET_MIN = 6'h01;  // Two slots at least
    localparam logic [5:0]  SLOT_IDLE    = 6'h3f;  // Outside any frame

    // ****************************************
    // Register map and bus constants
    // ****************************************
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_CLKDIV   = 8'h04;
    localparam logic [7:0]  OFS_TXDATA   = 8'h08;
    localparam logic [7:0]  OFS_RXDATA   = 8'h0c;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;
    localparam logic [7:0]  DIV_RST      = 8'h04;
    localparam int unsigned HTRANS_ACT   = 1;
    localparam logic        HRESP_OKAY   = 1'b0;

    // Synchroniser lanes for sampled pins
    localparam int unsigned SY_TXFS      = 0;
    localparam int unsigned SY_RXFS      = 1;
    localparam int unsigned SY_RXD       = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [4:0] slots_m1;
        logic [1:0] port_sel;
        logic       fs_word;
        logic       rx_frame_invert;
        logic       tx_frame_invert;
        logic       rx_clock_polarity;
        logic       tx_clock_polarity;
        logic       rx_int;
        logic       tx_int;
        logic       network;
        logic       gated;
        logic       sync;
        logic       rx_en;
        logic       tx_en;
    } tdmsp_ctrl_t;

    localparam int unsigned CTRL_W = $bits(tdmsp_ctrl_t);

    typedef struct packed {
        logic rx_ovr;
        logic tx_und;
        logic rx_full;
        logic tx_empty;
    } tdmsp_stat_t;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'b01,
        RX_SHIFT = 2'b10
    } tdmsp_rx_st_t;

    // ****************************************
    // Shared functions
    // ****************************************
    // Next {slot, bit} of a free-running frame
    function automatic logic [9:0] frame_step(input logic [3:0] b,
                                              input logic [5:0] s,
                                              input logic [5:0] last);
        logic [9:0] r;
        if (b != BIT_LAST) begin
            r = {s, b + 4'h1};
        end else if (s >= last) begin
            r = {SLOT_FIRST, BIT_FIRST};
        end else begin
            r = {s + 6'h01, BIT_FIRST};
        end
        return r;
    endfunction

    // Index of the last slot of a frame
    function automatic logic [5:0] last_slot(input tdmsp_ctrl_t c);
        logic [5:0] m;
        m = {1'b0, c.slots_m1};
        if (!c.network) begin
            return SLOT_FIRST;
        end
        return (m < SLOT_NET_MIN) ? SLOT_NET_MIN : m;
    endfunction

    // Active-high frame pulse for a position
    function automatic logic fs_level(input logic [5:0] s,
                                      input logic [3:0] b,
                                      input logic       word);
        return (s == SLOT_FIRST) & (word | (b == BIT_FIRST));
    endfunction

    // One-hot port-set mask
    function automatic logic [3:0] sel_mask(input logic [1:0] ps);
        return 4'h1 << ps;
    endfunction

endpackage

// [hdl/tdmsp_bclk.sv]
`timescale 1ns/100ps
module tdmsp_bclk
    import tdmsp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    // Mode and pin
    input  wire logic       i_internal,
    input  wire logic       i_run,
    input  wire logic [7:0] i_half_div,
    input  wire logic       i_pin,
    input  wire logic       i_invert,
    // Pin drive and edge strobes
    output logic            o_pin,
    output logic            o_launch,
    output logic            o_sample
);

    logic       sy1_q;
    logic       sy2_q;
    logic       core_q;
    logic       prev_q;
    logic       pin_q;
    logic [7:0] cnt_q;
    logic       core;

    // Two-flop synchroniser; only the second stage is read
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sy1_q <= 1'b0;
            sy2_q <= 1'b0;
        end else begin
            sy1_q <= i_pin;
            sy2_q <= sy1_q;
        end
    end

    // Divider; a gated clock only stops once back at idle low
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt_q  <= '0;
            core_q <= 1'b0;
        end else if (!i_internal || !(i_run || core_q)) begin
            cnt_q  <= '0;
            core_q <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q  <= i_half_div - 8'h01;
            core_q <= ~core_q;
        end else begin
            cnt_q  <= cnt_q - 8'h01;
        end
    end

    // Non-inverted view of the bit clock
    assign core = i_internal ? core_q : (sy2_q ^ i_invert);

    // Edge finder; pin lags core by one cycle like the strobes
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            prev_q <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            prev_q <= core;
            pin_q  <= core_q ^ i_invert;
        end
    end

    assign o_pin    = pin_q;
    assign o_launch = core & ~prev_q;
    assign o_sample = ~core & prev_q;

endmodule

// [hdl/tdmsp_top.sv]
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module tdmsp_top
    import tdmsp_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Transmit pins, one bit per port set
    input  wire logic [3:0]  i_tx_bit_clock,
    output logic      [3:0]  o_tx_bit_clock,
    output logic      [3:0]  o_tx_bit_clock_oe_n,
    input  wire logic [3:0]  i_tx_frame_pulse,
    output logic      [3:0]  o_tx_frame_pulse,
    output logic      [3:0]  o_tx_frame_pulse_oe_n,
    output logic      [3:0]  o_tx_serial_line,
    output logic      [3:0]  o_tx_serial_line_oe_n,
    // Receive pins, one bit per port set
    input  wire logic [3:0]  i_rx_bit_clock,
    output logic      [3:0]  o_rx_bit_clock,
    output logic      [3:0]  o_rx_bit_clock_oe_n,
    input  wire logic [3:0]  i_rx_frame_pulse,
    output logic      [3:0]  o_rx_frame_pulse,
    output logic      [3:0]  o_rx_frame_pulse_oe_n,
    input  wire logic [3:0]  i_rx_serial_line
);

    // ****************************************
    // Declarations
    // ****************************************
    tdmsp_ctrl_t          ctrl_q;
    tdmsp_ctrl_t          ctrl_wr;
    tdmsp_stat_t          stat;
    tdmsp_rx_st_t         rx_st_q;
    logic [7:0]           tx_div_q;
    logic [7:0]           rx_div_q;
    logic [WORD_BITS-1:0] tx_hold_q;
    logic [WORD_BITS-1:0] rx_data_q;
    logic [WORD_BITS-1:0] tx_shift_q;
    logic [WORD_BITS-1:0] rx_shift_q;
    logic                 tx_full_q;
    logic                 rx_full_q;
    logic                 rx_ovr_q;
    logic                 tx_und_q;
    logic                 dph_wr_q;
    logic [7:0]           dph_addr_q;
    logic [31:0]          hrdata_q;
    logic [31:0]          rd_mux;
    logic                 addr_take;
    logic                 rd_take;
    logic                 wr_ctrl;
    logic                 wr_div;
    logic                 wr_tx;
    logic                 rd_rx;
    logic                 rd_stat;
    logic [1:0]           ps;
    logic [5:0]           last;
    logic [2:0]           pin_raw;
    logic [2:0]           sync1_q;
    logic [2:0]           sync2_q;
    logic                 gated_eff;
    logic                 tx_run;
    logic                 rx_run;
    logic                 tx_ck;
    logic                 tx_launch;
    logic                 tx_sample;
    logic                 rx_ck;
    logic                 rx_launch;
    logic                 rx_sample;
    logic                 rx_smp;
    logic                 txfs_lvl;
    logic                 txfs_prev_q;
    logic                 fs_pend_q;
    logic [3:0]           tbit_q;
    logic [5:0]           tslot_q;
    logic [3:0]           tbit_d;
    logic [5:0]           tslot_d;
    logic                 wstart;
    logic                 tx_drv_q;
    logic                 txfs_pin_q;
    logic                 tx_consume;
    logic                 tx_und_ev;
    logic [3:0]           rg_bit_q;
    logic [5:0]           rg_slot_q;
    logic [9:0]           rg_step;
    logic                 rgfs_pin_q;
    logic                 rfs_lvl;
    logic                 rfs_prev_q;
    logic                 fs_rise;
    logic [3:0]           rbit_q;
    logic [5:0]           rslot_q;
    logic                 rx_store;
    logic                 rx_out_en;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    // Zero wait states; every answer is OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp     = HRESP_OKAY;
    assign o_hrdata    = hrdata_q;
    assign addr_take   = i_hsel & i_htrans[HTRANS_ACT] & i_hready;
    assign rd_take     = addr_take & ~i_hwrite;

    // Address phase is captured, write data applied in the data phase
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= '0;
        end else begin
            dph_wr_q   <= addr_take & i_hwrite;
            dph_addr_q <= i_haddr[7:0];
        end
    end

    assign wr_ctrl = dph_wr_q & (dph_addr_q == OFS_CTRL);
    assign wr_div  = dph_wr_q & (dph_addr_q == OFS_CLKDIV);
    assign wr_tx   = dph_wr_q & (dph_addr_q == OFS_TXDATA);
    assign rd_rx   = rd_take & (i_haddr[7:0] == OFS_RXDATA);
    assign rd_stat = rd_take & (i_haddr[7:0] == OFS_STATUS);
    assign stat    = '{rx_ovr: rx_ovr_q, tx_und: tx_und_q,
                       rx_full: rx_full_q, tx_empty: ~tx_full_q};

    // Read mux; unmapped words read zero
    always_comb begin
        unique case (i_haddr[7:0])
            OFS_CTRL:   rd_mux = 32'(ctrl_q);
            OFS_CLKDIV: rd_mux = 32'({rx_div_q, tx_div_q});
            OFS_TXDATA: rd_mux = 32'(tx_hold_q);
            OFS_RXDATA: rd_mux = 32'(rx_data_q);
            OFS_STATUS: rd_mux = 32'(stat);
            default:    rd_mux = '0;
        endcase
    end

    // Read data is registered so it stands through the data phase
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            hrdata_q <= '0;
        end else if (rd_take) begin
            hrdata_q <= rd_mux;
        end
    end

    // Control write never keeps gated together with network
    always_comb begin
        ctrl_wr       = tdmsp_ctrl_t'(i_hwdata[CTRL_W-1:0]);
        ctrl_wr.gated = ctrl_wr.gated & ~ctrl_wr.network;
    end

    // Configuration registers
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_q   <= '0;
            tx_div_q <= DIV_RST;
            rx_div_q <= DIV_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr;
            end
            if (wr_div) begin
                tx_div_q <= i_hwdata[7:0];
                rx_div_q <= i_hwdata[15:8];
            end
        end
    end

    // Data registers
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tx_hold_q <= '0;
            rx_data_q <= '0;
        end else begin
            if (wr_tx) begin
                tx_hold_q <= i_hwdata[WORD_BITS-1:0];
            end
            if (rx_store) begin
                rx_data_q <= {rx_shift_q[WORD_BITS-2:0], sync2_q[SY_RXD]};
            end
        end
    end

    // Status flags; a hardware set beats a clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tx_full_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_ovr_q  <= 1'b0;
            tx_und_q  <= 1'b0;
        end else begin
            tx_full_q <= wr_tx | (tx_full_q & ~tx_consume);
            rx_full_q <= rx_store | (rx_full_q & ~rd_rx);
            rx_ovr_q  <= (rx_store & rx_full_q) | (rx_ovr_q & ~rd_stat);
            tx_und_q  <= tx_und_ev | (tx_und_q & ~rd_stat);
        end
    end

    // ****************************************
    // Port-set routing and pin sampling
    // ****************************************
    assign ps      = ctrl_q.port_sel;
    assign pin_raw = {i_rx_serial_line[ps], i_rx_frame_pulse[ps],
                      i_tx_frame_pulse[ps]};

    // Two-flop synchronisers for the sampled pins
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // Bit clocks
    // ****************************************
    assign gated_eff = ctrl_q.gated & ~ctrl_q.network;
    assign tx_run    = ~gated_eff | (ctrl_q.tx_en & tx_full_q) | tx_drv_q;
    assign rx_run    = ~gated_eff | ctrl_q.rx_en;
    assign last      = last_slot(ctrl_q);

    tdmsp_bclk u_tx_bclk (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_internal (ctrl_q.tx_int),
        .i_run      (tx_run),
        .i_half_div (tx_div_q),
        .i_pin      (i_tx_bit_clock[ps]),
        .i_invert   (ctrl_q.tx_clock_polarity),
        .o_pin      (tx_ck),
        .o_launch   (tx_launch),
        .o_sample   (tx_sample)
    );

    tdmsp_bclk u_rx_bclk (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_internal (ctrl_q.rx_int),
        .i_run      (rx_run),
        .i_half_div (rx_div_q),
        .i_pin      (i_rx_bit_clock[ps]),
        .i_invert   (ctrl_q.rx_clock_polarity),
        .o_pin      (rx_ck),
        .o_launch   (rx_launch),
        .o_sample   (rx_sample)
    );

    // Receive sampling edge of the shared or the own clock
    assign rx_smp = ctrl_q.sync ? tx_sample : rx_sample;

    // ****************************************
    // Transmit framing and shifter
    // ****************************************
    assign txfs_lvl = sync2_q[SY_TXFS] ^ ctrl_q.tx_frame_invert;

    // External frame pulse seen on a sample edge starts the next word
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            txfs_prev_q <= 1'b0;
            fs_pend_q   <= 1'b0;
        end else if (tx_sample) begin
            txfs_prev_q <= txfs_lvl;
            if (txfs_lvl && !txfs_prev_q) begin
                fs_pend_q <= 1'b1;
            end
        end else if (tx_launch) begin
            fs_pend_q <= 1'b0;
        end
    end

    // Next bit position; external framing idles after the last slot
    always_comb begin
        {tslot_d, tbit_d} = frame_step(tbit_q, tslot_q, last);
        if (!ctrl_q.tx_int) begin
            if (fs_pend_q) begin
                {tslot_d, tbit_d} = {SLOT_FIRST, BIT_FIRST};
            end else if (tslot_q == SLOT_IDLE
                         || (tbit_q == BIT_LAST && tslot_q >= last)) begin
                {tslot_d, tbit_d} = {SLOT_IDLE, BIT_LAST};
            end
        end
        // Gated clock restarts on a word, never mid-frame with idle bits
        if (ctrl_q.tx_int && gated_eff && !tx_drv_q) begin
            {tslot_d, tbit_d} = {SLOT_FIRST, BIT_FIRST};
        end
    end

    assign wstart     = (tbit_d == BIT_FIRST) & (tslot_d != SLOT_IDLE);
    assign tx_consume = tx_launch & wstart & ctrl_q.tx_en & tx_full_q;
    // Gated clock stops when empty, so no underrun there
    assign tx_und_ev  = tx_launch & wstart & ctrl_q.tx_en & ~tx_full_q & ~gated_eff;

    // Transmit position, shifter, data drive and frame pin move on launch edges only
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tbit_q     <= BIT_LAST;
            tslot_q    <= SLOT_IDLE;
            tx_shift_q <= '0;
            tx_drv_q   <= 1'b0;
            txfs_pin_q <= 1'b0;
        end else if (tx_launch) begin
            tbit_q     <= tbit_d;
            tslot_q    <= tslot_d;
            txfs_pin_q <= fs_level(tslot_d, tbit_d, ctrl_q.fs_word)
                          ^ ctrl_q.tx_frame_invert;
            if (wstart) begin
                tx_drv_q   <= ctrl_q.tx_en & tx_full_q;
                tx_shift_q <= tx_hold_q;
            end else if (tslot_d == SLOT_IDLE) begin
                tx_drv_q   <= 1'b0;
            end else begin
                tx_shift_q <= {tx_shift_q[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Receive frame generator (async, internal clock)
    // ****************************************
    assign rg_step = frame_step(rg_bit_q, rg_slot_q, last);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rg_bit_q   <= BIT_LAST;
            rg_slot_q  <= SLOT_IDLE;
            rgfs_pin_q <= 1'b0;
        end else if (rx_launch) begin
            {rg_slot_q, rg_bit_q} <= rg_step;
            rgfs_pin_q <= fs_level(rg_step[9:4], rg_step[3:0], ctrl_q.fs_word)
                          ^ ctrl_q.rx_frame_invert;
        end
    end

    // Frame level seen by the receiver, always active high
    always_comb begin
        if (ctrl_q.sync) begin
            rfs_lvl = ctrl_q.tx_int ? (txfs_pin_q ^ ctrl_q.tx_frame_invert)
                                    : txfs_lvl;
        end else if (ctrl_q.rx_int) begin
            rfs_lvl = rgfs_pin_q ^ ctrl_q.rx_frame_invert;
        end else begin
            rfs_lvl = sync2_q[SY_RXFS] ^ ctrl_q.rx_frame_invert;
        end
    end

    // ****************************************
    // Receive shifter
    // ****************************************
    assign fs_rise  = rfs_lvl & ~rfs_prev_q;
    assign rx_store = rx_smp & ctrl_q.rx_en & ~fs_rise
                      & (rx_st_q == RX_SHIFT) & (rbit_q == BIT_LAST);

    // A fresh frame edge always restarts the word, even mid-word
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rfs_prev_q <= 1'b0;
            rx_st_q    <= RX_HUNT;
            rbit_q     <= BIT_FIRST;
            rslot_q    <= SLOT_FIRST;
            rx_shift_q <= '0;
        end else if (rx_smp) begin
            rfs_prev_q <= rfs_lvl;
            if (!ctrl_q.rx_en) begin
                rx_st_q <= RX_HUNT;
            end else if (fs_rise) begin
                rx_st_q    <= RX_SHIFT;
                rx_shift_q <= {rx_shift_q[WORD_BITS-2:0], sync2_q[SY_RXD]};
                {rslot_q, rbit_q} <= {SLOT_FIRST, BIT_FIRST + 4'h1};
            end else begin
                unique case (rx_st_q)
                    RX_HUNT: begin
                        rx_st_q <= RX_HUNT;
                    end
                    RX_SHIFT: begin
                        rx_shift_q <= {rx_shift_q[WORD_BITS-2:0],
                                       sync2_q[SY_RXD]};
                        {rslot_q, rbit_q} <= frame_step(rbit_q, rslot_q, last);
                        if (rbit_q == BIT_LAST && rslot_q >= last) begin
                            rx_st_q <= RX_HUNT;
                        end
                    end
                    default: begin
                        rx_st_q <= RX_HUNT;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Pin drivers; only the selected set is enabled
    // ****************************************
    assign rx_out_en = ~ctrl_q.sync & ctrl_q.rx_int;

    assign o_tx_bit_clock        = {4{tx_ck}};
    assign o_tx_bit_clock_oe_n   = ~(sel_mask(ps) & {4{ctrl_q.tx_int}});
    assign o_tx_frame_pulse      = {4{txfs_pin_q}};
    assign o_tx_frame_pulse_oe_n = ~(sel_mask(ps) & {4{ctrl_q.tx_int}});
    assign o_tx_serial_line      = {4{tx_shift_q[WORD_BITS-1]}};
    assign o_tx_serial_line_oe_n = ~(sel_mask(ps) & {4{tx_drv_q}});
    assign o_rx_bit_clock        = {4{rx_ck}};
    assign o_rx_bit_clock_oe_n   = ~(sel_mask(ps) & {4{rx_out_en}});
    assign o_rx_frame_pulse      = {4{rgfs_pin_q}};
    assign o_rx_frame_pulse_oe_n = ~(sel_mask(ps) & {4{rx_out_en}});

endmodule

// [sim/tdmsp_assertions.sv]
`timescale 1ns/100ps
module tdmsp_assertions (
    // Clock, reset and bus answer
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       o_hreadyout,
    input wire logic       o_hresp,
    // Pin drives
    input wire logic [3:0] o_tx_bit_clock,
    input wire logic [3:0] o_tx_bit_clock_oe_n,
    input wire logic [3:0] o_tx_frame_pulse,
    input wire logic [3:0] o_tx_frame_pulse_oe_n,
    input wire logic [3:0] o_tx_serial_line,
    input wire logic [3:0] o_tx_serial_line_oe_n,
    input wire logic [3:0] o_rx_bit_clock_oe_n,
    input wire logic [3:0] o_rx_frame_pulse_oe_n
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Polarity is not visible here, so any bit clock edge counts
    sequence clk_edge; $changed(o_tx_bit_clock); endsequence
    wire logic drv = ~&o_tx_bit_clock_oe_n;
    wire logic word = ~&o_tx_serial_line_oe_n;
    rdy_high_a: assert property (o_hreadyout) else $error("bus stalled");
    resp_okay_a: assert property (!o_hresp) else $error("bus error response");
    clk_alike_a: assert property (o_tx_bit_clock inside {4'h0, 4'hf}) else $error("clk sets");
    fs_alike_a: assert property (o_tx_frame_pulse inside {4'h0, 4'hf}) else $error("fs sets");
    one_set_a: assert property ($onehot0(~o_tx_serial_line_oe_n)) else $error("two sets");
    rx_one_set_a: assert property ($onehot0(~o_rx_bit_clock_oe_n)) else $error("rx sets");
    pair_drive_a: assert property (o_tx_bit_clock_oe_n == o_tx_frame_pulse_oe_n)
        else $error("tx clk and fs drive differ");
    rx_pair_a: assert property (o_rx_bit_clock_oe_n == o_rx_frame_pulse_oe_n)
        else $error("rx clk and fs drive differ");
    data_launch_a: assert property (drv && word && $changed(o_tx_serial_line) |-> clk_edge)
        else $error("data off edge");
    fs_launch_a: assert property (drv && $changed(o_tx_frame_pulse) |-> clk_edge)
        else $error("fs off edge");
    float_edge_a: assert property (drv && $changed(o_tx_serial_line_oe_n) |-> clk_edge)
        else $error("float off edge");
endmodule

// [sim/tdmsp_codec_model.sv]
`timescale 1ns/100ps
module tdmsp_codec_model (
    // Link pins
    input  wire logic        i_clk,
    input  wire logic        i_fs,
    input  wire logic        i_txd,
    output logic             o_rxd,
    // Last word heard
    output logic      [15:0] o_got
);
    localparam logic [15:0] REPLY = 16'h3c5a;
    logic [15:0] cap;
    int          k = -1;
    int          n = 16;
    initial o_rxd = 1'b0;
    initial o_got = 16'h0000;
    // Answer MSB first after each rising edge; outside a word the line toggles
    always @(posedge i_clk) begin
        #1;
        k = i_fs ? 15 : k - 1;
        o_rxd = (k >= 0) ? REPLY[k] : ~o_rxd;
    end
    // Capture on falling edges, one word per frame pulse
    always @(negedge i_clk) begin
        if (i_fs) n = 0;
        cap = {cap[14:0], i_txd};
        n = n + 1;
        if (n == 16) o_got = cap;
    end
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps
module tb;
    import tdmsp_pkg::*;
    logic        i_mclk, i_sys_rst, i_hsel, i_hwrite, o_hreadyout, o_hresp, rxd;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic [3:0]  t_ck, t_ck_e, t_fs, t_fs_e, t_d, t_d_e, r_ck, r_ck_e, r_fs, r_fs_e;
    logic [15:0] got;
    int          failures = 0;
    int          samples_checked = 0;
    int          n;
    // Released pins fall to their pull-downs
    wire  [3:0]  tck = t_ck & ~t_ck_e;
    wire  [3:0]  tfs = t_fs & ~t_fs_e;
    wire  [3:0]  rck = r_ck & ~r_ck_e;
    wire  [3:0]  rfs = r_fs & ~r_fs_e;
    tdmsp_top tdmsp_top_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_tx_bit_clock(tck),
        .o_tx_bit_clock(t_ck), .o_tx_bit_clock_oe_n(t_ck_e), .i_tx_frame_pulse(tfs),
        .o_tx_frame_pulse(t_fs), .o_tx_frame_pulse_oe_n(t_fs_e), .o_tx_serial_line(t_d),
        .o_tx_serial_line_oe_n(t_d_e), .i_rx_bit_clock(rck), .o_rx_bit_clock(r_ck),
        .o_rx_bit_clock_oe_n(r_ck_e), .i_rx_frame_pulse(rfs), .o_rx_frame_pulse(r_fs),
        .o_rx_frame_pulse_oe_n(r_fs_e), .i_rx_serial_line({4{rxd}}));
    tdmsp_codec_model tdmsp_codec_model_i (.i_clk(tck[2]), .i_fs(tfs[2]),
        .i_txd(t_d[2] & ~t_d_e[2]), .o_rxd(rxd), .o_got(got));
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bounded wait for hready at the next edges
    task automatic ready_edge();
        int k;
        k = 0;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                failures++;
                wrap_up();
            end
            @(posedge i_mclk);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge i_mclk);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_hwrite <= w;
        i_haddr <= {24'h00_0000, a};
        ready_edge();
        i_hsel <= 1'b0;
        i_htrans <= 2'b00;
        i_hwdata <= d;
        ready_edge();
        r = o_hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        chk(r, e);
    endtask
    // Reset, defaults, then one synchronous word each way on set c
    initial begin
        logic [31:0] s;
        {i_sys_rst, i_hsel, i_hwrite, i_htrans, i_hsize} = 8'h82;
        {i_haddr, i_hwdata} = 64'h0000_0000_0000_0000;
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(OFS_CTRL, 32'h0000_0000);
        rd(OFS_CLKDIV, 32'h0000_0404);
        rd(OFS_STATUS, 32'h0000_0001);
        rd(8'h20, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0018);
        rd(OFS_CTRL, 32'h0000_0010);
        wr(OFS_TXDATA, 32'h0000_a5c3);
        wr(OFS_CTRL, 32'h0000_2027);
        for (n = 0; n < 300 && t_d_e === 4'hf; n++) @(posedge i_mclk);
        chk(32'(n >= 300), 32'h0000_0000);
        chk({28'h000_0000, t_d_e}, 32'h0000_000b);
        chk({24'h00_0000, t_fs_e, r_ck_e}, 32'h0000_00bf);
        s = 32'h0000_0000;
        for (n = 0; n < 100 && s[1] !== 1'b1; n++) ahb(1'b0, OFS_STATUS, s, s);
        chk(32'(n >= 100), 32'h0000_0000);
        rd(OFS_RXDATA, 32'h0000_3c5a);
        chk({16'h0000, got}, 32'h0000_a5c3);
        repeat (20) @(posedge i_mclk);
        rd(OFS_STATUS, 32'h0000_0005);
        // Gated clock: stands low when empty, runs for one word on a write
        wr(OFS_CTRL, 32'h0000_2029);
        repeat (20) @(posedge i_mclk);
        s = {28'h000_0000, t_ck};
        repeat (4) @(posedge i_mclk);
        chk({s[27:0], t_ck}, 32'h0000_0000);
        wr(OFS_TXDATA, 32'h0000_1234);
        repeat (150) @(posedge i_mclk);
        chk({got, 12'h000, t_ck}, 32'h1234_0000);
        wrap_up();
    end
endmodule
bind tdmsp_top tdmsp_assertions tdmsp_assertions_i (.*);
